/* ctxbe_element.sv */
/*
 * Transmit buffer element reader. Fetches one element word by word from the
 * message memory, decodes the header for the framer, emits payload bytes in
 * ascending order and returns the marker byte for the event FIFO.
 * Assumes a memory answering one word per mem_req after any wait, synchronous
 * inputs, and a framer that takes one byte per byte_ready cycle.
 */
`timescale 1ns/1ps
`include "ctxbe_regs.svh"
module ctxbe_element #(
    parameter int IDX_W = 5,
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [IDX_W-1:0] element_index,
    input wire logic [ADDR_W-1:0] section_base,
    input wire logic [IDX_W:0] dedicated_tx_buffer_count,
    input wire logic [IDX_W:0] tx_fifo_queue_size,
    input wire ctxbe_pkg::ctxbe_esz_t tx_element_size_config,
    input wire logic fd_operation_enable,
    input wire logic error_passive,
    input wire logic byte_ready,
    input wire ctxbe_pkg::ctxbe_word_t mem_rdata,
    input wire logic mem_rvalid,
    output logic mem_req,
    output logic [ADDR_W-1:0] mem_addr,
    output logic busy,
    output logic slot_error,
    output logic slot_is_fifo_queue,
    output logic hdr_valid,
    output ctxbe_pkg::ctxbe_hdr_s hdr,
    output logic byte_valid,
    output logic [7:0] payload_byte,
    output logic last_byte,
    output logic event_valid,
    output logic [7:0] event_marker
);
    import ctxbe_pkg::*;

    ctxbe_state_e state_q, state_d;
    ctxbe_word_t w0_q, data_q;
    ctxbe_hdr_s hdr_d;
    logic [6:0] bytes_left_q, nbytes, esz_bytes, send_bytes;
    logic [1:0] lane_q, lane_next;
    logic [7:0] lane_byte_next;
    logic [ADDR_W-1:0] elem_base, word_addr_q;
    logic [ADDR_W-1:0] elem_words;
    logic remote_eff, fd_eff, word_taken, byte_go;

    ctxbe_map_if #(.IDX_W(IDX_W)) map_bus ();
    assign map_bus.index = element_index;
    assign map_bus.ded_count = dedicated_tx_buffer_count;
    assign map_bus.fq_size = tx_fifo_queue_size;
    ctxbe_slot_map #(.IDX_W(IDX_W)) u_map (.m(map_bus));

    // Element stride from size config: 8,12,16,20,24,32,48,64 data bytes
    always_comb begin
        case (tx_element_size_config)
            3'h0: esz_bytes = 7'h08;
            3'h1: esz_bytes = 7'h0c;
            3'h2: esz_bytes = 7'h10;
            3'h3: esz_bytes = 7'h14;
            3'h4: esz_bytes = 7'h18;
            3'h5: esz_bytes = 7'h20;
            3'h6: esz_bytes = 7'h30;
            default: esz_bytes = 7'(`CTXBE_MAX_DATA_BYTES);
        endcase
    end
    assign elem_words = ADDR_W'(`CTXBE_HDR_WORDS) + ADDR_W'(esz_bytes[6:2]);
    assign elem_base = section_base + ADDR_W'(element_index) * elem_words;

    // Length code to byte count; FD codes only count when FD is really sent
    always_comb begin
        if (!fd_eff || mem_rdata[`CTXBE_W1_DLC_HI:`CTXBE_W1_DLC_LO] <= `CTXBE_CLASSIC_MAX_DLC) begin
            nbytes = (mem_rdata[`CTXBE_W1_DLC_HI:`CTXBE_W1_DLC_LO] > `CTXBE_CLASSIC_MAX_DLC) ? 7'h08
                : 7'(mem_rdata[`CTXBE_W1_DLC_HI:`CTXBE_W1_DLC_LO]);
        end else begin
            case (mem_rdata[`CTXBE_W1_DLC_HI:`CTXBE_W1_DLC_LO])
                4'h9: nbytes = 7'h0c;
                4'ha: nbytes = 7'h10;
                4'hb: nbytes = 7'h14;
                4'hc: nbytes = 7'h18;
                4'hd: nbytes = 7'h20;
                4'he: nbytes = 7'h30;
                default: nbytes = 7'h40;
            endcase
        end
    end

    // Header decode from word 0 (held) and word 1 (arriving)
    assign remote_eff = w0_q[`CTXBE_W0_RTR];
    assign fd_eff = fd_operation_enable && mem_rdata[`CTXBE_W1_FDF] && !remote_eff;
    assign send_bytes = remote_eff ? 7'h00 : ((nbytes > esz_bytes) ? esz_bytes : nbytes);
    always_comb begin
        hdr_d.esi = fd_eff && (w0_q[`CTXBE_W0_ESI] | error_passive);
        hdr_d.extended = w0_q[`CTXBE_W0_EXT_ID];
        hdr_d.remote = remote_eff;
        hdr_d.fd = fd_eff;
        hdr_d.brs = fd_eff && mem_rdata[`CTXBE_W1_BRS];
        hdr_d.efc = mem_rdata[`CTXBE_W1_EVT_STORE];
        hdr_d.dlc = mem_rdata[`CTXBE_W1_DLC_HI:`CTXBE_W1_DLC_LO];
        hdr_d.marker = mem_rdata[`CTXBE_W1_MARK_HI:`CTXBE_W1_MARK_LO];
        // Standard id lives in 28:18, right-justified for the framer
        hdr_d.id = w0_q[`CTXBE_W0_EXT_ID] ? w0_q[`CTXBE_ID_HI:0]
            : {18'h00000, w0_q[`CTXBE_ID_HI:`CTXBE_STD_LO]};
    end

    assign word_taken = mem_rvalid && mem_req;
    assign byte_go = byte_valid && byte_ready;

    // Sequencer: word 0, word 1, then payload words
    always_comb begin
        state_d = state_q;
        case (state_q)
            CTXBE_IDLE: if (start && map_bus.in_range) state_d = CTXBE_HDR0;
            CTXBE_HDR0: if (word_taken) state_d = CTXBE_HDR1;
            CTXBE_HDR1: if (word_taken) state_d = (send_bytes == 7'h00) ? CTXBE_IDLE : CTXBE_DATA;
            CTXBE_DATA: if (byte_go && bytes_left_q == 7'h01) state_d = CTXBE_IDLE;
            default: state_d = CTXBE_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) state_q <= CTXBE_IDLE;
        else state_q <= state_d;
    end

    // Memory request side; one word fetched per four bytes sent
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mem_req <= 1'b0;
            mem_addr <= '0;
            word_addr_q <= '0;
        end else if (state_q == CTXBE_IDLE && start && map_bus.in_range) begin
            mem_req <= 1'b1;
            mem_addr <= elem_base;
            word_addr_q <= elem_base;
        end else if (word_taken) begin
            mem_req <= (state_q == CTXBE_HDR0) || (state_q == CTXBE_HDR1 && send_bytes != 7'h00);
            mem_addr <= word_addr_q + 1'b1;
            word_addr_q <= word_addr_q + 1'b1;
        end else if (byte_go && lane_q == 2'h3 && bytes_left_q != 7'h01) begin
            mem_req <= 1'b1; // Next payload word only once the current one is drained
        end
    end

    // Header capture, status and event marker
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            w0_q <= '0;
            hdr <= '0;
            hdr_valid <= 1'b0;
            event_valid <= 1'b0;
            event_marker <= 8'h00;
            slot_error <= 1'b0;
            slot_is_fifo_queue <= 1'b0;
            busy <= 1'b0;
        end else begin
            hdr_valid <= 1'b0;
            event_valid <= 1'b0;
            busy <= (state_d != CTXBE_IDLE);
            if (state_q == CTXBE_IDLE && start) begin
                slot_error <= !map_bus.in_range;
                slot_is_fifo_queue <= map_bus.is_fifo_queue;
            end
            if (state_q == CTXBE_HDR0 && word_taken) w0_q <= mem_rdata;
            if (state_q == CTXBE_HDR1 && word_taken) begin
                hdr <= hdr_d;
                hdr_valid <= 1'b1;
                event_valid <= 1'b1;
                event_marker <= hdr_d.marker;
            end
        end
    end

    // Payload bytes leave lowest lane first; the byte is registered so the framer never sees the lane mux
    assign lane_next = lane_q + 2'h1;
    assign lane_byte_next = data_q[8*lane_next +: 8];
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            data_q <= '0;
            lane_q <= 2'h0;
            payload_byte <= 8'h00;
            bytes_left_q <= 7'h00;
            byte_valid <= 1'b0;
            last_byte <= 1'b0;
        end else begin
            if (state_q == CTXBE_HDR1 && word_taken) bytes_left_q <= send_bytes;
            if (state_q == CTXBE_DATA && word_taken) begin
                data_q <= mem_rdata;
                lane_q <= 2'h0;
                payload_byte <= mem_rdata[7:0];
                byte_valid <= 1'b1;
                last_byte <= (bytes_left_q == 7'h01);
            end else if (byte_go) begin
                bytes_left_q <= bytes_left_q - 7'h01;
                lane_q <= lane_next;
                payload_byte <= lane_byte_next;
                byte_valid <= (lane_q != 2'h3) && (bytes_left_q != 7'h01);
                last_byte <= (bytes_left_q == 7'h02);
            end
        end
    end

    // Checks
    property p_esi_or;
        @(posedge sys_clk) disable iff (reset)
        hdr_valid && hdr.fd |-> hdr.esi == ($past(w0_q[`CTXBE_W0_ESI]) | $past(error_passive));
    endproperty
    a_esi_or: assert property (p_esi_or) else $error("esi not or of request and passive");
    property p_passive_recessive;
        @(posedge sys_clk) disable iff (reset)
        hdr_valid && hdr.fd && $past(error_passive) |-> hdr.esi;
    endproperty
    a_passive_recessive: assert property (p_passive_recessive) else $error("passive node sent esi dominant");
    property p_remote_classic;
        @(posedge sys_clk) disable iff (reset) hdr_valid && hdr.remote |-> !hdr.fd && !hdr.brs;
    endproperty
    a_remote_classic: assert property (p_remote_classic) else $error("remote frame sent as fd");
    property p_rtr_bit;
        @(posedge sys_clk) disable iff (reset) hdr_valid |-> hdr.remote == $past(w0_q[`CTXBE_W0_RTR]);
    endproperty
    a_rtr_bit: assert property (p_rtr_bit) else $error("frame type does not follow bit 29");
    property p_std_id;
        @(posedge sys_clk) disable iff (reset)
        hdr_valid && !hdr.extended |-> hdr.id == {18'h00000, $past(w0_q[`CTXBE_ID_HI:`CTXBE_STD_LO])};
    endproperty
    a_std_id: assert property (p_std_id) else $error("standard id not taken from 28:18");
    property p_marker;
        @(posedge sys_clk) disable iff (reset)
        hdr_valid |-> event_valid && event_marker == $past(mem_rdata[`CTXBE_W1_MARK_HI:`CTXBE_W1_MARK_LO]);
    endproperty
    a_marker: assert property (p_marker) else $error("marker not copied to event");
    property p_base;
        @(posedge sys_clk) disable iff (reset)
        state_q == CTXBE_IDLE && start && map_bus.in_range |=> mem_req && mem_addr == $past(elem_base);
    endproperty
    a_base: assert property (p_base) else $error("element fetch address wrong");
    property p_ded_first;
        @(posedge sys_clk) disable iff (reset)
        state_q == CTXBE_IDLE && start && {1'b0, element_index} < dedicated_tx_buffer_count |=> !slot_is_fifo_queue;
    endproperty
    a_ded_first: assert property (p_ded_first) else $error("dedicated slot classed as fifo");
    property p_byte_cap;
        @(posedge sys_clk) disable iff (reset)
        hdr_valid && hdr.fd && hdr.dlc == 4'hf && tx_element_size_config == 3'h7
        |-> bytes_left_q == 7'(`CTXBE_MAX_DATA_BYTES);
    endproperty
    a_byte_cap: assert property (p_byte_cap) else $error("largest element does not hold 64 bytes");
    property p_lane_order;
        @(posedge sys_clk) disable iff (reset) byte_go && !last_byte |=> lane_q == $past(lane_q) + 2'h1;
    endproperty
    a_lane_order: assert property (p_lane_order) else $error("bytes not ascending");
    c_remote: cover property (@(posedge sys_clk) hdr_valid && hdr.remote);
    c_fd_ext: cover property (@(posedge sys_clk) hdr_valid && hdr.fd && hdr.extended);
    c_last: cover property (@(posedge sys_clk) byte_go && last_byte);
    c_fifo: cover property (@(posedge sys_clk) hdr_valid && slot_is_fifo_queue);
endmodule : ctxbe_element

/* ctxbe_regs.svh */
/*
 * Constants for the transmit buffer element decoder: element word fields,
 * header length, classic length limit and the largest element data field size in bytes and words.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef CTXBE_REGS_SVH
`define CTXBE_REGS_SVH

`define CTXBE_W0_ESI 31
`define CTXBE_W0_EXT_ID 30
`define CTXBE_W0_RTR 29
`define CTXBE_ID_HI 28
`define CTXBE_STD_LO 18
`define CTXBE_W1_MARK_HI 31
`define CTXBE_W1_MARK_LO 24
`define CTXBE_W1_EVT_STORE 23
`define CTXBE_W1_FDF 21
`define CTXBE_W1_BRS 20
`define CTXBE_W1_DLC_HI 19
`define CTXBE_W1_DLC_LO 16
`define CTXBE_HDR_WORDS 2
`define CTXBE_MAX_DATA_BYTES 64
`define CTXBE_MAX_DATA_WORDS 16
`define CTXBE_CLASSIC_MAX_DLC 4'h8

`endif

/* ctxbe_pkg.sv */
/*
 * Types shared by the element decoder files.
 * Assumes ctxbe_regs.svh is on the include path.
 */
package ctxbe_pkg;
    typedef logic [31:0] ctxbe_word_t;
    typedef logic [2:0] ctxbe_esz_t;
    typedef enum logic [1:0] {
        CTXBE_IDLE = 2'b00,
        CTXBE_HDR0 = 2'b01,
        CTXBE_HDR1 = 2'b11,
        CTXBE_DATA = 2'b10
    } ctxbe_state_e;
    // Decoded frame header handed to the bit-stream framer
    typedef struct packed {
        logic esi;
        logic extended;
        logic remote;
        logic fd;
        logic brs;
        logic efc;
        logic [28:0] id;
        logic [7:0] marker;
        logic [3:0] dlc;
    } ctxbe_hdr_s;
endpackage : ctxbe_pkg

/* ctxbe_map_if.sv */
/*
 * Interface carrying the element placement query between the top and the
 * slot mapper. Assumes both ends run on sys_clk.
 */
`timescale 1ns/1ps
interface ctxbe_map_if #(parameter int IDX_W = 5);
    logic [IDX_W-1:0] index;
    logic [IDX_W:0] ded_count;
    logic [IDX_W:0] fq_size;
    logic is_dedicated;
    logic is_fifo_queue;
    logic in_range;
    modport requester (output index, output ded_count, output fq_size,
        input is_dedicated, input is_fifo_queue, input in_range);
    modport mapper (input index, input ded_count, input fq_size,
        output is_dedicated, output is_fifo_queue, output in_range);
endinterface : ctxbe_map_if

/* ctxbe_slot_map.sv */
/*
 * Classifies a transmit element index as dedicated buffer or FIFO/queue slot.
 * Assumes the configuration fields are static while a frame is read.
 */
`timescale 1ns/1ps
module ctxbe_slot_map #(parameter int IDX_W = 5) (
    ctxbe_map_if.mapper m
);
    import ctxbe_pkg::*;
    logic [IDX_W:0] idx_ext;
    logic [IDX_W+1:0] fq_end;
    // Dedicated buffers first, the FIFO/queue block right after them
    assign idx_ext = {1'b0, m.index};
    assign fq_end = {1'b0, m.ded_count} + {1'b0, m.fq_size};
    assign m.is_dedicated = idx_ext < m.ded_count;
    assign m.is_fifo_queue = !m.is_dedicated && ({1'b0, idx_ext} < fq_end);
    assign m.in_range = m.is_dedicated || m.is_fifo_queue;
endmodule : ctxbe_slot_map

/* ctxbe_mem_model.sv */
/*
 * Behavioural message memory facing the element reader: one word per request.
 * Assumes the reader holds mem_req and mem_addr until mem_rvalid is seen high.
 */
`timescale 1ns/1ps
module ctxbe_mem_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] wait_cycles,
    input wire logic mem_req,
    input wire logic [11:0] mem_addr,
    output ctxbe_pkg::ctxbe_word_t mem_rdata,
    output logic mem_rvalid
);
    import ctxbe_pkg::*;
    ctxbe_word_t mem [0:255];
    logic [3:0] wait_q;
    // Answer after wait_cycles; data is inverted outside valid so stale words cannot pass
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mem_rvalid <= 1'b0;
            wait_q <= 4'h0;
            mem_rdata <= 32'h0;
        end else if (mem_req && !mem_rvalid && wait_q >= wait_cycles) begin
            mem_rvalid <= 1'b1;
            mem_rdata <= mem[mem_addr[7:0]];
            wait_q <= 4'h0;
        end else begin
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_q <= mem_req ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule : ctxbe_mem_model

/* tb.sv */
/*
 * Self-checking bench for the element reader with a behavioural memory.
 * Assumes the design defaults IDX_W 5 and ADDR_W 12.
 */
`timescale 1ns/1ps
module tb;
    import ctxbe_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [4:0] element_index = 5'h0;
    logic [2:0] esz = 3'h0;
    logic fd_enable = 1'b0;
    logic ep = 1'b0;
    logic byte_ready = 1'b1;
    logic [3:0] wait_cycles = 4'h0;
    ctxbe_word_t mem_rdata;
    logic mem_rvalid, mem_req, busy, slot_error, slot_fq, hdr_valid, byte_valid, last_byte, event_valid;
    logic [11:0] mem_addr;
    ctxbe_hdr_s hdr;
    logic [7:0] payload_byte, event_marker;
    int miscompares = 0;
    int n_checks = 0;
    int sz_tab [8] = '{8, 12, 16, 20, 24, 32, 48, 64};
    int dlc_tab [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 16, 20, 24, 32, 48, 64};
    always #4 sys_clk = ~sys_clk;
    ctxbe_element i_dut (.sys_clk(sys_clk), .reset(reset), .start(start), .element_index(element_index),
        .section_base(12'h010), .dedicated_tx_buffer_count(6'h02), .tx_fifo_queue_size(6'h03),
        .tx_element_size_config(esz), .fd_operation_enable(fd_enable), .error_passive(ep), .byte_ready(byte_ready),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_req(mem_req), .mem_addr(mem_addr), .busy(busy),
        .slot_error(slot_error), .slot_is_fifo_queue(slot_fq), .hdr_valid(hdr_valid), .hdr(hdr),
        .byte_valid(byte_valid), .payload_byte(payload_byte), .last_byte(last_byte),
        .event_valid(event_valid), .event_marker(event_marker));
    ctxbe_mem_model i_mem (.sys_clk(sys_clk), .reset(reset), .wait_cycles(wait_cycles), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // Payload pattern differs per byte so lane swaps show
    function automatic logic [7:0] pat(input int n);
        return 8'(n * 7 + 3);
    endfunction : pat
    // Fetch one element and judge address, header, marker and every payload byte
    task automatic run_frame(input logic [4:0] idx, input ctxbe_word_t w0, input ctxbe_word_t w1,
            input logic [2:0] sz, input logic fd_en, input logic pas, input logic [3:0] wt);
        logic [11:0] a;
        logic fdf;
        ctxbe_hdr_s e;
        int n, nb, cyc;
        logic got_hdr, got_addr;
        a = 12'h010 + 12'(idx) * 12'(2 + sz_tab[sz] / 4);
        fdf = fd_en & w1[21] & ~w0[29];
        n = dlc_tab[w1[19:16]];
        if (!fdf && n > 8) n = 8;
        if (w0[29]) n = 0;
        if (n > sz_tab[sz]) n = sz_tab[sz];
        e = '{fdf & (w0[31] | pas), w0[30], w0[29], fdf, fdf & w1[20], w1[23],
            w0[30] ? w0[28:0] : {18'h0, w0[28:18]}, w1[31:24], w1[19:16]};
        i_mem.mem[a] = w0;
        i_mem.mem[a + 12'h1] = w1;
        for (int k = 0; k < 16; k++) i_mem.mem[a + 12'h2 + 12'(k)] = {pat(4*k+3), pat(4*k+2), pat(4*k+1), pat(4*k)};
        @(posedge sys_clk);
        #1;
        {element_index, esz, fd_enable, ep, wait_cycles, start} = {idx, sz, fd_en, pas, wt, 1'b1};
        @(posedge sys_clk);
        #1;
        start = 1'b0;
        {nb, got_hdr, got_addr} = 0;
        for (cyc = 0; cyc < 600 && !(got_hdr && nb == n && busy === 1'b0); cyc++) begin
            @(posedge sys_clk);
            if (mem_req === 1'b1 && !got_addr) check("element address", mem_addr, a);
            if (mem_req === 1'b1) got_addr = 1'b1;
            if (hdr_valid === 1'b1) begin
                got_hdr = 1'b1;
                check("header", 64'(hdr), 64'(e));
                check("event pulse", event_valid, 1'b1);
                check("event marker", event_marker, w1[31:24]);
                check("fifo slot flag", slot_fq, idx >= 5'h2);
            end
            if (byte_valid === 1'b1 && byte_ready === 1'b1) begin
                check("payload byte", payload_byte, nb < n ? pat(nb) : 8'hxx);
                check("last byte", last_byte, nb == n - 1);
                nb++;
            end
            #1;
            byte_ready = (cyc % 4) != 3; // Framer stalls one cycle in four
        end
        if (cyc >= 600) begin
            miscompares++;
            $display("Error frame wait expected completion seen timeout");
            results();
        end
    endtask : run_frame
    // Classic standard frame: ESI forced low, long code clamped to eight bytes
    task automatic s_classic_std();
        run_frame(5'h0, 32'h8968_1234, 32'hc38b_0000, 3'h0, 1'b0, 1'b1, 4'h0);
    endtask : s_classic_std
    // FD extended frame filling the largest element from a queue slot, slow memory
    task automatic s_fd_ext();
        run_frame(5'h4, 32'h41ab_cdef, 32'h3c3f_0000, 3'h7, 1'b1, 1'b0, 4'h2);
    endtask : s_fd_ext
    // Element size truncation and a partial last word
    task automatic s_trunc_partial();
        run_frame(5'h2, 32'h4000_0077, 32'h013d_0000, 3'h1, 1'b1, 1'b0, 4'h1);
        run_frame(5'h1, 32'h0440_0000, 32'h0205_0000, 3'h2, 1'b1, 1'b0, 4'h0);
    endtask : s_trunc_partial
    // Every ESI request against every error passive level in FD, walking the middle size codes
    task automatic s_esi_table();
        for (int k = 0; k < 4; k++) run_frame(5'h3, {k[0], 31'h0100_0000}, 32'h5530_0000, 3'(k + 3), 1'b1, k[1], 4'h0);
    endtask : s_esi_table
    // Remote request with FD enabled stays a classic frame with no payload
    task automatic s_remote();
        run_frame(5'h0, 32'h2123_4000, 32'h7738_0000, 3'h7, 1'b1, 1'b0, 4'h0);
    endtask : s_remote
    // Slot beyond both regions is refused without a fetch
    task automatic s_out_of_range();
        @(posedge sys_clk);
        #1;
        {element_index, start} = {5'h5, 1'b1};
        @(posedge sys_clk);
        #1;
        start = 1'b0;
        repeat (4) begin
            @(posedge sys_clk);
            check("refused fetch", mem_req, 1'b0);
        end
        check("slot error", slot_error, 1'b1);
    endtask : s_out_of_range
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        check("idle after reset", {busy, mem_req, hdr_valid, byte_valid}, 4'h0);
        s_classic_std();
        s_fd_ext();
        s_trunc_partial();
        s_esi_table();
        s_remote();
        s_out_of_range();
        results();
    end
endmodule : tb
